/* pkg/uis_defines.vh */
`ifndef UIS_DEFINES_VH
`define UIS_DEFINES_VH
// Function
// [RL1] writing one to a flag bit clears it; writing zero leaves it alone
// [RL2] software clears all set flags before enabling new interrupt events
// [RL3] flags set on events regardless of the master irq enable state
// [RL4] bit 9 sets on isochronous descriptor completion
// [RL5] bit 8 sets on async transfer list descriptor completion
// [RL6] software writes reserved bits 31 to 10, 4, 2, 1 as zero
// [RL7] bit 7 sets on periodic interrupt descriptor completion
// [RL8] bit 6 sets once internal clocks run stably
// [RL9] bit 5 sets when the host controller enters suspend
// [RL10] bit 3 sets when a dma transfer completes
// [RL11] bit 0 sets on each start of frame; all flags zero after reset

// ***************
// register map
// ***************
`define UIS_ADDR_W        16
`define UIS_FLAGS_OFFSET  16'h0310
`define UIS_FLAGS_RESET   32'h0000_0000
`define UIS_FLAGS_MASK    32'h0000_03E9
`define UIS_BIT_ISO       9
`define UIS_BIT_ASYNC     8
`define UIS_BIT_PERIODIC  7
`define UIS_BIT_CLOCKS    6
`define UIS_BIT_SUSPEND   5
`define UIS_BIT_DMA       3
`define UIS_BIT_FRAME     0
`endif

/* src/uis_irq_status.v */
`include "uis_defines.vh"

module uis_irq_status (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // register access, core clock domain
   input  wire        reg_sel_i,
   input  wire        reg_wr_i,
   input  wire [15:0] reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   output wire [31:0] reg_rdata_o,
   // event pulses from the controller core, same clock
   input  wire        iso_done_i,
   input  wire        async_done_i,
   input  wire        periodic_done_i,
   input  wire        clocks_stable_i,
   input  wire        suspend_entered_i,
   input  wire        dma_done_i,
   input  wire        frame_start_i,
   input  wire        master_irq_enable_i,
   // flag levels for the irq pin logic
   output wire [31:0] flags_o
);

   // ***************
   // constants
   // ***************
   localparam [31:0] RESET_V = `UIS_FLAGS_RESET;
   localparam [31:0] KEEP_M  = `UIS_FLAGS_MASK;

   // ***************
   // functions
   // ***************
   // one address decode shared by the read and the write strobe
   function addr_hit;
      input        sel;
      input [15:0] addr;
      begin
         addr_hit = sel && (addr == `UIS_FLAGS_OFFSET);
      end
   endfunction

   // write one to clear; the event wins so a same-cycle event is never lost
   function flag_next;
      input cur;
      input set;
      input clr;
      begin
         flag_next = set | (cur & ~clr);
      end
   endfunction

   // ***************
   // storage
   // ***************
   reg         iso_list_done_flag_q;
   reg         iso_list_done_flag_d;
   reg         async_list_done_flag_q;
   reg         async_list_done_flag_d;
   reg         periodic_done_flag_q;
   reg         periodic_done_flag_d;
   reg         clocks_stable_flag_q;
   reg         clocks_stable_flag_d;
   reg         suspend_entered_flag_q;
   reg         suspend_entered_flag_d;
   reg         dma_complete_flag_q;
   reg         dma_complete_flag_d;
   reg         frame_start_flag_q;
   reg         frame_start_flag_d;
   reg  [31:0] rdata_q;
   reg  [31:0] rdata_d;
   wire [31:0] flags_w;
   wire [31:0] clr_w;
   wire        wr_hit_w;
   wire        rd_hit_w;

   // ***************
   // access decode
   // ***************
   assign wr_hit_w = addr_hit(reg_sel_i, reg_addr_i) && reg_wr_i;
   assign rd_hit_w = addr_hit(reg_sel_i, reg_addr_i) && !reg_wr_i;

   // reserved bits never store, so stray ones from software are harmless
   assign clr_w = wr_hit_w ? (reg_wdata_i & KEEP_M) : 32'h0000_0000;   // see [RL1]

   // master_irq_enable_i is left unread on purpose: flags record events
   // whether or not the pin logic is allowed to raise an interrupt
   // see [RL3]

   // ***************
   // bit 9, isochronous descriptor completion
   // ***************
   always @* begin
      iso_list_done_flag_d = flag_next(iso_list_done_flag_q,
                                       iso_done_i,
                                       clr_w[`UIS_BIT_ISO]);       // see [RL4]
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         iso_list_done_flag_q <= RESET_V[`UIS_BIT_ISO];            // see [RL11]
      end else begin
         iso_list_done_flag_q <= iso_list_done_flag_d;
      end
   end

   // ***************
   // bit 8, async transfer list descriptor completion
   // ***************
   always @* begin
      async_list_done_flag_d = flag_next(async_list_done_flag_q,
                                         async_done_i,
                                         clr_w[`UIS_BIT_ASYNC]);   // see [RL5]
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         async_list_done_flag_q <= RESET_V[`UIS_BIT_ASYNC];        // see [RL11]
      end else begin
         async_list_done_flag_q <= async_list_done_flag_d;
      end
   end

   // ***************
   // bit 7, periodic interrupt descriptor completion
   // ***************
   always @* begin
      periodic_done_flag_d = flag_next(periodic_done_flag_q,
                                       periodic_done_i,
                                       clr_w[`UIS_BIT_PERIODIC]);  // see [RL7]
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         periodic_done_flag_q <= RESET_V[`UIS_BIT_PERIODIC];       // see [RL11]
      end else begin
         periodic_done_flag_q <= periodic_done_flag_d;
      end
   end

   // ***************
   // bit 6, internal clocks stable
   // ***************
   always @* begin
      clocks_stable_flag_d = flag_next(clocks_stable_flag_q,
                                       clocks_stable_i,
                                       clr_w[`UIS_BIT_CLOCKS]);    // see [RL8]
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clocks_stable_flag_q <= RESET_V[`UIS_BIT_CLOCKS];         // see [RL11]
      end else begin
         clocks_stable_flag_q <= clocks_stable_flag_d;
      end
   end

   // ***************
   // bit 5, suspend entered
   // ***************
   always @* begin
      suspend_entered_flag_d = flag_next(suspend_entered_flag_q,
                                         suspend_entered_i,
                                         clr_w[`UIS_BIT_SUSPEND]); // see [RL9]
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         suspend_entered_flag_q <= RESET_V[`UIS_BIT_SUSPEND];      // see [RL11]
      end else begin
         suspend_entered_flag_q <= suspend_entered_flag_d;
      end
   end

   // ***************
   // bit 3, dma transfer complete
   // ***************
   always @* begin
      dma_complete_flag_d = flag_next(dma_complete_flag_q,
                                      dma_done_i,
                                      clr_w[`UIS_BIT_DMA]);        // see [RL10]
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dma_complete_flag_q <= RESET_V[`UIS_BIT_DMA];             // see [RL11]
      end else begin
         dma_complete_flag_q <= dma_complete_flag_d;
      end
   end

   // ***************
   // bit 0, start of frame
   // ***************
   always @* begin
      frame_start_flag_d = flag_next(frame_start_flag_q,
                                     frame_start_i,
                                     clr_w[`UIS_BIT_FRAME]);       // see [RL11]
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_start_flag_q <= RESET_V[`UIS_BIT_FRAME];            // see [RL11]
      end else begin
         frame_start_flag_q <= frame_start_flag_d;
      end
   end

   // ***************
   // register image
   // ***************
   // reserved positions are tied low so they always read zero
   assign flags_w = {22'h00_0000,
                     iso_list_done_flag_q,
                     async_list_done_flag_q,
                     periodic_done_flag_q,
                     clocks_stable_flag_q,
                     suspend_entered_flag_q,
                     1'h0,
                     dma_complete_flag_q,
                     2'h0,
                     frame_start_flag_q};

   // ***************
   // read path
   // ***************
   // the read returns the flags as they stood at the strobe edge; an event in
   // the same cycle is not visible until the next read
   always @* begin
      rdata_d = rd_hit_w ? flags_w : 32'h0000_0000;
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ***************
   // outputs
   // ***************
   // both outputs come from flip-flops with no logic between
   assign flags_o     = flags_w;
   assign reg_rdata_o = rdata_q;

endmodule

/* sim/uis_irq_status_asserts.sv */
module uis_irq_status_asserts (
   input wire logic clk_i, rst_n_i, reg_sel_i, reg_wr_i, iso_done_i, async_done_i,
   input wire logic periodic_done_i, clocks_stable_i, suspend_entered_i, dma_done_i,
   input wire logic frame_start_i, master_irq_enable_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i, reg_rdata_o, flags_o);
   wire [31:0] ev = {22'h0, iso_done_i, async_done_i, periodic_done_i, clocks_stable_i,
      suspend_entered_i, 1'b0, dma_done_i, 2'h0, frame_start_i};
   wire hit = reg_sel_i && reg_addr_i == 16'h0310;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_set; !(hit && reg_wr_i) |=> flags_o == $past(flags_o | ev); endproperty
   a_set: assert property (p_set) else $error("set");
   property p_clr; hit && reg_wr_i |=> flags_o == $past(flags_o & ~reg_wdata_i | ev); endproperty
   a_clr: assert property (p_clr) else $error("clr");
   property p_rd; hit && !reg_wr_i |=> reg_rdata_o == $past(flags_o); endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_rd_idle; !(hit && !reg_wr_i) |=> reg_rdata_o == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_rsv; flags_o[31:10] == 22'h0 && flags_o[4] == 1'b0 && flags_o[2:1] == 2'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved flag set");
   property p_iso; iso_done_i |=> flags_o[9]; endproperty
   a_iso: assert property (p_iso) else $error("iso flag missed");
   cover property (hit && reg_wr_i);
   cover property (ev[8]);
   cover property (hit && !reg_wr_i);
endmodule
bind uis_irq_status uis_irq_status_asserts chk_inst (.*);

/* sim/uis_irq_status_tb.sv */
module uis_irq_status_tb;
   timeunit 1ns / 1ns;
   logic clk_i = 0, rst_n_i = 0, sel = 0, wr = 0, en = 0;
   logic [15:0] addr = 16'h0310;
   logic [6:0] ev = 0;
   logic [31:0] wd = 0, rd, fl;
   int error_cnt = 0, cmp_count = 0, b [7] = '{0, 3, 5, 6, 7, 8, 9};
   always #5 clk_i = ~clk_i;
   uis_irq_status uis_irq_status_inst (.clk_i, .rst_n_i, .reg_sel_i(sel), .reg_wr_i(wr),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rd), .frame_start_i(ev[0]),
      .dma_done_i(ev[1]), .suspend_entered_i(ev[2]), .clocks_stable_i(ev[3]),
      .periodic_done_i(ev[4]), .async_done_i(ev[5]), .iso_done_i(ev[6]),
      .master_irq_enable_i(en), .flags_o(fl));
   task chk(string n, logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin error_cnt++; $display("MISMATCH %s %h %h", n, e, g); end
   endtask
   task acc(logic w, logic [31:0] d, logic [15:0] a = 16'h0310);
      @(negedge clk_i) {sel, wr, addr, wd} = {1'b1, w, a, d};
      @(negedge clk_i) sel = 0;
   endtask
   task conclude;
      $display("%0d compares %0d mismatches", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_n_i = 1;
      chk("rst", 0, fl);
      for (int k = 0; k < 7; k++) begin
         @(negedge clk_i) begin ev[k] = 1; en = k[0]; end
         @(negedge clk_i) ev[k] = 0;
         acc(0, 0);
         chk("rd", 1 << b[k], rd);
         acc(1, 0);
         chk("keep", 1 << b[k], fl);
         acc(1, 1 << b[k]);
         chk("clr", 0, fl);
         $display("event %0d done", k);
      end
      @(negedge clk_i) ev[5] = 1;
      @(negedge clk_i) ev[5] = 0;
      acc(1, 32'h0000_0100, 16'h0314);
      chk("far_wr", 32'h0000_0100, fl);
      acc(0, 0, 16'h0314);
      chk("far_rd", 0, rd);
      @(negedge clk_i) {sel, wr, addr, wd, ev[5]} = {1'b1, 1'b1, 16'h0310, 32'h0000_0100, 1'b1};
      @(negedge clk_i) {sel, ev[5]} = 2'b00;
      chk("set_wins", 32'h0000_0100, fl);
      acc(1, 32'h0000_0100);
      chk("clr2", 0, fl);
      $display("address and collision tests done");
      @(negedge clk_i) ev[0] = 1;
      @(negedge clk_i) begin ev[0] = 0; rst_n_i = 0; end
      #1 chk("mid_rst", 0, fl);
      repeat (2) @(negedge clk_i);
      rst_n_i = 1;
      acc(0, 0);
      chk("rst_rd", 0, rd);
      $display("reset test done");
      conclude;
   end
   initial begin #20us; error_cnt++; conclude; end
endmodule
